// *** rtl/rtc_i2c_pkg.sv ***
// Shared constants and carrier types for the two-wire register target.
// Assumes one clock domain at 25 MHz; bus pins arrive asynchronously.
package rtc_i2c_pkg;

    localparam logic [6:0] BUS_ADDR      = 7'h68;
    localparam logic [7:0] PTR_RESET     = 8'h00;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam int         REG_COUNT     = 256;
    localparam logic [7:0] MEM_RESET     = 8'h00;

    // Bus write and read request toward the register store
    typedef struct packed {
        logic       wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } regReq_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_PTR  = 5'b00100,
        ST_WDAT = 5'b01000,
        ST_RDAT = 5'b10000
    } busState_t;

endpackage

// *** rtl/rtc_reg_mem.sv ***
// Register store of the target: 256 bytes, registered read data.
// Assumes requests from the bus engine on the same clock.
`timescale 1ns/100ps
module rtc_reg_mem
    import rtc_i2c_pkg::*;
(
    input  wire logic       clk,
    input  wire regReq_t    req,
    output logic [7:0]      rdData
);
    logic [7:0] mem [REG_COUNT];

    always_ff @(posedge clk) begin
        if (req.wrEn) begin
            mem[req.addr] <= req.wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdData <= mem[req.addr];
    end
endmodule // rtc_reg_mem

// *** rtl/rtc_i2c_target.sv ***
// Two-wire target: address decode, register pointer, byte write and read.
// Assumes SCL and SDA are external open-drain lines sampled by clk.
`timescale 1ns/100ps
module rtc_i2c_target
    import rtc_i2c_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe
);
    logic [1:0] sclSync_r;
    logic [1:0] sdaSync_r;
    logic       sclPrev_r;
    logic       sdaPrev_r;
    busState_t  state_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic       drive_r;
    logic       ackPhase_r;
    logic [7:0] rdData;
    regReq_t    req;

    wire scl      = sclSync_r[1];
    wire sda      = sdaSync_r[1];
    wire sclRise  = scl & ~sclPrev_r;
    wire sclFall  = ~scl & sclPrev_r;
    wire startCnd = scl & sclPrev_r & sdaPrev_r & ~sda;
    wire stopCnd  = scl & sclPrev_r & ~sdaPrev_r & sda;
    wire byteDone = sclRise & (bitCnt_r == BIT_LAST);
    wire [7:0] rxByte = {shift_r[6:0], sda};
    wire ackRise  = sclRise & (bitCnt_r == BIT_ACK);
    // Ninth clock answered by the controller, not our own acknowledge
    wire txAckRise = ackRise & ~ackPhase_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], sclIn};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            sclPrev_r <= sclSync_r[1];
            sdaPrev_r <= sdaSync_r[1];
        end
    end

    // Bit counter: 0..7 data, 8 acknowledge; advances on SCL fall.
    // START parks it on the ack slot so the fall after START opens bit 0.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitCnt_r <= 4'h0;
        end else if (startCnd) begin
            bitCnt_r <= BIT_ACK;
        end else if (sclFall) begin
            bitCnt_r <= (bitCnt_r == BIT_ACK) ? 4'h0 : bitCnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else if (startCnd) begin
            state_r <= ST_ADDR;
        end else if (stopCnd) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: state_r <= ST_IDLE;
                ST_ADDR: if (byteDone) begin
                    if (rxByte[7:1] != BUS_ADDR) begin
                        state_r <= ST_IDLE;
                    end else if (rxByte[0]) begin
                        state_r <= ST_RDAT;
                    end else begin
                        state_r <= ST_PTR;
                    end
                end
                ST_PTR:  if (byteDone) state_r <= ST_WDAT;
                ST_WDAT: state_r <= ST_WDAT;
                ST_RDAT: if (txAckRise && sda) begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Receive shift register, MSB first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
        end else if (sclRise && bitCnt_r <= BIT_LAST) begin
            shift_r <= rxByte;
        end
    end

    // Pointer survives transfers; only writes and reads move it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_r <= PTR_RESET;
        end else if (byteDone && state_r == ST_PTR) begin
            ptr_r <= rxByte;
        end else if (byteDone && state_r == ST_WDAT) begin
            ptr_r <= ptr_r + 8'h01;
        end else if (txAckRise && state_r == ST_RDAT) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    always_comb begin
        req.addr   = ptr_r;
        req.wrData = rxByte;
        req.wrEn   = byteDone && state_r == ST_WDAT;
    end

    rtc_reg_mem u_mem (
        .clk    (clk),
        .req    (req),
        .rdData (rdData)
    );

    // Set when the byte just received is ours to acknowledge; decided
    // before the state moves on, so a read address is acked as well
    always_ff @(posedge clk) begin
        if (!rst_n || startCnd || stopCnd) begin
            ackPhase_r <= 1'b0;
        end else if (byteDone) begin
            ackPhase_r <= state_r == ST_PTR || state_r == ST_WDAT ||
                (state_r == ST_ADDR && rxByte[7:1] == BUS_ADDR);
        end
    end

    // SDA driver: low for acknowledge, read data bits otherwise
    always_ff @(posedge clk) begin
        if (!rst_n || startCnd || stopCnd) begin
            drive_r <= 1'b0;
        end else if (sclFall) begin
            if (bitCnt_r == BIT_LAST) begin
                drive_r <= ackPhase_r;
            end else if (state_r == ST_RDAT && bitCnt_r == BIT_ACK) begin
                drive_r <= ~rdData[7];
            end else if (state_r == ST_RDAT && bitCnt_r < BIT_LAST) begin
                drive_r <= ~rdData[3'h6 - bitCnt_r[2:0]];
            end else begin
                drive_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdaOut <= 1'b0;
            sdaOe  <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            sdaOe  <= drive_r;
        end
    end

    a_addr_ack: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_ADDR && byteDone && rxByte[7:1] == BUS_ADDR)
        |-> ##[1:400] drive_r)
        else $error("address match not acknowledged");

    a_ptr_load: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_PTR && byteDone && !startCnd && !stopCnd)
        |=> ptr_r == $past(rxByte))
        else $error("pointer not loaded");

    a_wr_inc: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_WDAT && byteDone)
        |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer not advanced on write");

    a_rd_inc: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_RDAT && txAckRise)
        |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer not advanced on read");

    a_nack_end: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_RDAT && txAckRise && sda && !startCnd && !stopCnd)
        |=> state_r == ST_IDLE)
        else $error("read not ended by nack");

    a_start_go: assert property (@(posedge clk) disable iff (!rst_n)
        startCnd |=> state_r == ST_ADDR && bitCnt_r == BIT_ACK)
        else $error("start not recognised");

    a_stop_end: assert property (@(posedge clk) disable iff (!rst_n)
        (stopCnd && !startCnd) |=> state_r == ST_IDLE ##1 !sdaOe)
        else $error("stop not ending transfer");

    a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_IDLE && $past(state_r) == ST_IDLE &&
         $past(state_r, 2) == ST_IDLE) |-> !sdaOe)
        else $error("line driven while idle");

    a_bad_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_ADDR && byteDone && rxByte[7:1] != BUS_ADDR &&
         !startCnd && !stopCnd) |=> state_r == ST_IDLE)
        else $error("foreign address accepted");
endmodule // rtc_i2c_target

// *** bench/ctl_model.sv ***
// Two-wire bus controller model: drives SCL and pulls SDA low.
// Assumes a pull-up on SDA and an 8-clock SCL period.
`timescale 1ns/100ps
module ctl_model (
    input  wire logic clk,
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaPull
);
    initial begin
        sclOut  = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data moves 3 clocks into SCL low, sampled late in SCL high
    task automatic bitTx(input logic b, output logic r);
        tick(3);
        sdaPull <= ~b;
        tick(1);
        sclOut <= 1'b1;
        tick(3);
        @(negedge clk) r = sdaLine;
        @(posedge clk) sclOut <= 1'b0;
    endtask

    task automatic sta();
        tick(5);
        sdaPull <= 1'b0;
        tick(1);
        sclOut <= 1'b1;
        tick(4);
        sdaPull <= 1'b1;
        tick(4);
        sclOut <= 1'b0;
    endtask

    task automatic sto();
        tick(3);
        sdaPull <= 1'b1;
        tick(2);
        sclOut <= 1'b1;
        tick(4);
        sdaPull <= 1'b0;
        tick(8);
    endtask

    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitTx(b[i], r);
        bitTx(1'b1, r);
        ack = ~r;
    endtask

    // Read one byte, acknowledge it when ak is set, then report line level
    task automatic rdByte(input logic ak, output logic [7:0] d,
                          output logic rel);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitTx(1'b1, r);
            d[i] = r;
        end
        bitTx(~ak, rel);
    endtask
endmodule // ctl_model

// *** bench/tb_top.sv ***
// Testbench for the two-wire register target.
// Assumes the controller model as bus partner and a pull-up on SDA.
`timescale 1ns/100ps
module tb_top;
    import rtc_i2c_pkg::*;
    logic      clk;
    logic      rst_n;
    logic      sclOut;
    logic      sdaPull;
    logic      sdaOut;
    logic      sdaOe;
    wire logic sdaLine;
    int        miscompares = 0;
    int        n_checks = 0;

    assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;

    rtc_i2c_target rtc_i2c_target_i (.clk(clk), .rst_n(rst_n),
        .sclIn(sclOut), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
    ctl_model ctl_model_i (.clk(clk), .sdaLine(sdaLine),
        .sclOut(sclOut), .sdaPull(sdaPull));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] b, input logic expAck);
        logic a;
        ctl_model_i.wrByte(b, a);
        check({7'h00, a}, {7'h00, expAck});
    endtask

    task automatic rd(input logic ak, input logic [7:0] exp);
        logic [7:0] d;
        logic       rel;
        ctl_model_i.rdByte(ak, d, rel);
        check(d, exp);
        if (!ak) check({7'h00, rel}, 8'h01);
    endtask

    task automatic writeBurst();
        ctl_model_i.sta();
        wr({BUS_ADDR, 1'b0}, 1'b1);
        wr(8'h10, 1'b1);
        for (int i = 0; i < 4; i++) wr(8'ha0 + 8'(i), 1'b1);
        ctl_model_i.sto();
    endtask

    // Pointer set, repeated start, then sequential read
    task automatic readBack();
        ctl_model_i.sta();
        wr({BUS_ADDR, 1'b0}, 1'b1);
        wr(8'h10, 1'b1);
        ctl_model_i.sta();
        wr({BUS_ADDR, 1'b1}, 1'b1);
        rd(1'b1, 8'ha0);
        rd(1'b1, 8'ha1);
        rd(1'b0, 8'ha2);
        ctl_model_i.sto();
    endtask

    // Other addresses get no acknowledge and change nothing
    task automatic foreign();
        ctl_model_i.sta();
        wr({BUS_ADDR ^ 7'h01, 1'b0}, 1'b0);
        wr(8'h00, 1'b0);
        ctl_model_i.sto();
        ctl_model_i.sta();
        wr({BUS_ADDR ^ 7'h40, 1'b1}, 1'b0);
        ctl_model_i.sto();
    endtask

    task automatic readCurrent(input logic [7:0] exp);
        ctl_model_i.sta();
        wr({BUS_ADDR, 1'b1}, 1'b1);
        rd(1'b0, exp);
        ctl_model_i.sto();
    endtask

    // Pointer-only write, then read from it
    task automatic zeroData();
        ctl_model_i.sta();
        wr({BUS_ADDR, 1'b0}, 1'b1);
        wr(8'h12, 1'b1);
        ctl_model_i.sto();
        ctl_model_i.sta();
        wr({BUS_ADDR, 1'b1}, 1'b1);
        rd(1'b1, 8'ha2);
        rd(1'b0, 8'ha3);
        ctl_model_i.sto();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        check({7'h00, sdaOe}, 8'h00);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        writeBurst();
        readBack();
        foreign();
        readCurrent(8'ha3);
        zeroData();
        wrap_up();
    end
endmodule // tb_top
